// ===== verilog/pwm_regs_pkg.sv
/*
  Package for the PWM update and interrupt register block: register
  offsets, field positions, reset values and the event source order.
  Assumes a 32-bit word register port with byte addresses.
*/
package pwm_regs_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_CAPTURE_CH1 = 12'h100;
  localparam logic [11:0] OFS_CAPTURE_CH2 = 12'h104;
  localparam logic [11:0] OFS_CAPTURE_STATE = 12'h108;
  localparam logic [11:0] OFS_UPDATE_CFG = 12'h10C;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h110;
  localparam logic [11:0] OFS_IRQ_RAW = 12'h114;
  localparam logic [11:0] OFS_IRQ_MASKED = 12'h118;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h11C;

  // Update configuration field positions
  localparam int POS_GLOBAL_EN = 0;
  localparam int POS_GLOBAL_FORCE = 1;
  localparam int POS_OP0_EN = 2;
  localparam int POS_OP0_FORCE = 3;
  localparam int POS_OP1_EN = 4;
  localparam int POS_OP1_FORCE = 5;
  localparam int POS_OP2_EN = 6;
  localparam int POS_OP2_FORCE = 7;
  localparam int UPDATE_CFG_BITS = 8;

  // Interrupt source positions (common to enable, raw, masked, clear)
  localparam int POS_TIMER_STOP = 0;
  localparam int POS_TIMER_ZERO = 3;
  localparam int POS_TIMER_PERIOD = 6;
  localparam int POS_FAULT_START = 9;
  localparam int POS_FAULT_END = 12;
  localparam int POS_COMPARE_A = 15;
  localparam int POS_COMPARE_B = 18;
  localparam int POS_FAULT_CBC = 21;
  localparam int POS_FAULT_OST = 24;
  localparam int POS_CAPTURE = 27;
  localparam int IRQ_SOURCES = 30;

  // Reset values
  localparam logic [31:0] RST_CAPTURE = 32'h0000_0000;
  localparam logic [7:0] RST_UPDATE_CFG = 8'h00;
  localparam logic [29:0] RST_IRQ = 30'h0000_0000;

  // Event pulses from the PWM submodules, three instances each
  typedef struct packed {
    logic [2:0] capture;
    logic [2:0] fault_ost;
    logic [2:0] fault_cbc;
    logic [2:0] compare_b_event;
    logic [2:0] compare_a_event;
    logic [2:0] fault_end;
    logic [2:0] fault_start;
    logic [2:0] timer_period_event;
    logic [2:0] timer_zero_event;
    logic [2:0] timer_stop;
  } pwm_events_s;

  // Update strobes towards the operators
  typedef struct packed {
    logic [2:0] op_forced_refresh;
    logic [2:0] op_refresh_allowed;
    logic global_forced_refresh;
  } update_ctrl_s;

endpackage : pwm_regs_pkg

// ===== verilog/toggle_detect.sv
/*
  Toggle detector: pulses for one cycle when a software bit changes.
  Assumes the bit comes from a register on the same clock.
*/
`timescale 1ns/100ps
module toggle_detect (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Watched bit and change pulse
  input wire logic level,
  output logic pulse
);

  typedef struct packed {
    logic last;
    logic pulse;
  } state_s;

  state_s state;
  state_s next_state;

  // Compare against the value of the previous cycle
  always_comb begin
    next_state = state;
    next_state.last = level;
    next_state.pulse = level ^ state.last;
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign pulse = state.pulse;

endmodule // toggle_detect

// ===== verilog/irq_status_bit.sv
/*
  One sticky interrupt status bit with enable gating.
  Assumes event and clear are one-cycle pulses on mclk.
*/
`timescale 1ns/100ps
module irq_status_bit (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Control
  input wire logic event_in,
  input wire logic clear,
  input wire logic enable,
  // Status
  output logic raw,
  output logic masked
);

  typedef struct packed {
    logic raw;
  } state_s;

  state_s state;
  state_s next_state;

  // Set wins over a clear in the same cycle
  always_comb begin
    next_state = state;
    if (event_in) begin
      next_state.raw = 1'b1;
    end else if (clear) begin
      next_state.raw = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign raw = state.raw;
  assign masked = state.raw & enable;

endmodule // irq_status_bit

// ===== verilog/pwm_update_and_irq_regs.sv
/*
  Register block of a motor-control PWM unit: capture values, the
  shadow-to-active update controls and 30 interrupt sources.
  Assumes event pulses and capture strobes arrive on mclk, one cycle
  each, from the timers, operators, fault handlers and capture channels.
*/
// The strobed register port was left to the implementer.
// Summary of operation
// - Capture channel 1 value is a read-only word reset to zero.
// - Capture channel 2 value is a read-only word reset to zero.
// - Any change of an operator forced-update bit forces its update.
// - Normal operator updates need its enable and the global enable.
// - Any change of the global forced-update bit forces all updates.
// - One global enable bit gates the normal operator updates but not the forced ones.
// - Each source has a read-write enable bit reset to zero.
// - Each source has a raw status bit set regardless of enable.
// - Captures on channels 0, 1 and 2 are interrupt sources.
// - One-shot and cycle-by-cycle fault actions per pair are sources.
// - Compare A and B events of operators 0 to 2 are sources.
// - Timer period, zero and stop events of timers 0 to 2 are sources.
// - Start and end of fault events 0 to 2 are separate sources.
// - Masked status is raw status ANDed with the enable bit.
// - Writing one to a clear bit clears that raw status bit.
`timescale 1ns/100ps
module pwm_update_and_irq_regs (
  // Clock, reset and clock enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Capture values latched by the capture channels
  input wire logic [31:0] capture_timer,
  input wire logic [31:0] capture_state_in,
  // Event pulses from the PWM submodules
  input wire pwm_regs_pkg::pwm_events_s events,
  // Update controls towards the operators
  output pwm_regs_pkg::update_ctrl_s update_ctrl,
  // Interrupt output
  output logic irq
);

  typedef struct packed {
    logic [31:0] capture_value_ch1;
    logic [31:0] capture_value_ch2;
    logic [pwm_regs_pkg::UPDATE_CFG_BITS-1:0] active_update_config;
    logic [pwm_regs_pkg::IRQ_SOURCES-1:0] irq_enable;
    logic [31:0] rdata;
    logic irq;
    pwm_regs_pkg::update_ctrl_s update_ctrl;
  } state_s;

  state_s state;
  state_s next_state;

  logic [pwm_regs_pkg::IRQ_SOURCES-1:0] event_vec;
  logic [pwm_regs_pkg::IRQ_SOURCES-1:0] clear_vec;
  logic [pwm_regs_pkg::IRQ_SOURCES-1:0] irq_raw_status;
  logic [pwm_regs_pkg::IRQ_SOURCES-1:0] irq_masked_status;
  logic [3:0] force_bits;
  logic [3:0] force_pulse;
  logic wr_clear;

  assign event_vec = {events.capture, events.fault_ost, events.fault_cbc,
                      events.compare_b_event, events.compare_a_event,
                      events.fault_end, events.fault_start,
                      events.timer_period_event, events.timer_zero_event,
                      events.timer_stop};

  assign wr_clear = reg_write && (reg_addr == pwm_regs_pkg::OFS_IRQ_CLEAR);
  assign clear_vec = wr_clear ? reg_wdata[pwm_regs_pkg::IRQ_SOURCES-1:0]
                              : '0;

  // Sticky status bits, one per source
  genvar gi;
  generate
    for (gi = 0; gi < pwm_regs_pkg::IRQ_SOURCES; gi++) begin : g_src
      irq_status_bit u_bit (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .event_in(event_vec[gi]),
        .clear(clear_vec[gi]),
        .enable(state.irq_enable[gi]),
        .raw(irq_raw_status[gi]),
        .masked(irq_masked_status[gi])
      );
    end
  endgenerate

  // Forced-update bits watched for a change
  assign force_bits = {
    state.active_update_config[pwm_regs_pkg::POS_OP2_FORCE],
    state.active_update_config[pwm_regs_pkg::POS_OP1_FORCE],
    state.active_update_config[pwm_regs_pkg::POS_OP0_FORCE],
    state.active_update_config[pwm_regs_pkg::POS_GLOBAL_FORCE]};

  generate
    for (gi = 0; gi < 4; gi++) begin : g_force
      toggle_detect u_tog (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .level(force_bits[gi]),
        .pulse(force_pulse[gi])
      );
    end
  endgenerate

  // Register writes, read mux, update strobes and interrupt line
  always_comb begin
    logic [31:0] rd;
    logic gen;
    rd = 32'h0000_0000;
    gen = 1'b0;
    next_state = state;
    if (events.capture[1]) begin
      next_state.capture_value_ch1 = capture_timer;
    end
    if (events.capture[2]) begin
      next_state.capture_value_ch2 = capture_timer;
    end
    if (reg_write) begin
      unique case (reg_addr)
        pwm_regs_pkg::OFS_UPDATE_CFG: begin
          next_state.active_update_config =
            reg_wdata[pwm_regs_pkg::UPDATE_CFG_BITS-1:0];
        end
        pwm_regs_pkg::OFS_IRQ_ENABLE: begin
          next_state.irq_enable =
            reg_wdata[pwm_regs_pkg::IRQ_SOURCES-1:0];
        end
        default: begin
        end
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        pwm_regs_pkg::OFS_CAPTURE_CH1: rd = state.capture_value_ch1;
        pwm_regs_pkg::OFS_CAPTURE_CH2: rd = state.capture_value_ch2;
        pwm_regs_pkg::OFS_CAPTURE_STATE: rd = capture_state_in;
        pwm_regs_pkg::OFS_UPDATE_CFG: begin
          rd[pwm_regs_pkg::UPDATE_CFG_BITS-1:0] =
            state.active_update_config;
        end
        pwm_regs_pkg::OFS_IRQ_ENABLE: begin
          rd[pwm_regs_pkg::IRQ_SOURCES-1:0] = state.irq_enable;
        end
        pwm_regs_pkg::OFS_IRQ_RAW: begin
          rd[pwm_regs_pkg::IRQ_SOURCES-1:0] = irq_raw_status;
        end
        pwm_regs_pkg::OFS_IRQ_MASKED: begin
          rd[pwm_regs_pkg::IRQ_SOURCES-1:0] = irq_masked_status;
        end
        default: rd = 32'h0000_0000;
      endcase
    end
    next_state.rdata = rd;
    gen = state.active_update_config[pwm_regs_pkg::POS_GLOBAL_EN];
    next_state.update_ctrl.op_refresh_allowed = {
      gen & state.active_update_config[pwm_regs_pkg::POS_OP2_EN],
      gen & state.active_update_config[pwm_regs_pkg::POS_OP1_EN],
      gen & state.active_update_config[pwm_regs_pkg::POS_OP0_EN]};
    next_state.update_ctrl.op_forced_refresh = force_pulse[3:1];
    next_state.update_ctrl.global_forced_refresh = force_pulse[0];
    next_state.irq = |irq_masked_status;
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state.capture_value_ch1 <= pwm_regs_pkg::RST_CAPTURE;
      state.capture_value_ch2 <= pwm_regs_pkg::RST_CAPTURE;
      state.active_update_config <= pwm_regs_pkg::RST_UPDATE_CFG;
      state.irq_enable <= pwm_regs_pkg::RST_IRQ;
      state.rdata <= 32'h0000_0000;
      state.irq <= 1'b0;
      state.update_ctrl <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign update_ctrl = state.update_ctrl;
  assign irq = state.irq;

endmodule // pwm_update_and_irq_regs

// ===== testbench/pwm_regs_checker.sv
/*
  Port checker for the PWM update and interrupt register block.
  Assumes it is bound to the block's top module and that every port
  of that module reaches it under the same name.
*/
`timescale 1ns/100ps
module pwm_regs_checker (
  // Clock, reset and clock enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  // Events and block outputs
  input wire logic [31:0] capture_timer,
  input wire logic [31:0] capture_state_in,
  input wire pwm_regs_pkg::pwm_events_s events,
  input wire pwm_regs_pkg::update_ctrl_s update_ctrl,
  input wire logic irq
);
  logic [29:0] raw, ena, clr;
  logic [31:0] c1, c2;
  logic [7:0] cfg, tog;
  logic [3:0] f1, f2, f3;
  logic [2:0] alw;
  logic wr, rd;

  // Decoded strobes, clear mask, force toggles and allowed updates
  assign wr = reg_write && clk_en;
  assign rd = reg_read && clk_en;
  assign clr = (wr && reg_addr == 12'h11C) ? reg_wdata[29:0] : 30'h0;
  assign tog = (wr && reg_addr == 12'h10C) ? reg_wdata[7:0] ^ cfg : 8'h0;
  assign alw = {cfg[6], cfg[4], cfg[2]} & {3{cfg[0]}};

  // Shadow of the block state, rebuilt from port traffic
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {raw, ena, c1, c2, cfg, f1, f2, f3} <= '0;
    end else if (clk_en) begin
      raw <= (raw & ~clr) | events;
      if (wr && reg_addr == 12'h110) ena <= reg_wdata[29:0];
      if (wr && reg_addr == 12'h10C) cfg <= reg_wdata[7:0];
      if (events.capture[1]) c1 <= capture_timer;
      if (events.capture[2]) c2 <= capture_timer;
      f1 <= {tog[7], tog[5], tog[3], tog[1]};
      f2 <= f1;
      f3 <= f2;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_CAP1: assert property (rd && reg_addr == 12'h100 |=>
    reg_rdata == $past(c1)) else $error("capture 1 read wrong");
  AST_CAP2: assert property (rd && reg_addr == 12'h104 |=>
    reg_rdata == $past(c2)) else $error("capture 2 read wrong");
  AST_CAP_STATE: assert property (rd && reg_addr == 12'h108 |=>
    reg_rdata == $past(capture_state_in)) else $error("state read wrong");
  AST_OP_FORCE: assert property (
    update_ctrl.op_forced_refresh == f3[3:1]) else $error("op force");
  AST_ALLOWED: assert property (
    update_ctrl.op_refresh_allowed == $past(alw)) else $error("allowed");
  AST_GLOBAL_FORCE: assert property (
    update_ctrl.global_forced_refresh == f3[0]) else $error("global");
  AST_ENABLE: assert property (rd && reg_addr == 12'h110 |=>
    reg_rdata == {2'h0, $past(ena)}) else $error("enable read wrong");
  AST_RAW: assert property (rd && reg_addr == 12'h114 |=>
    reg_rdata == {2'h0, $past(raw)}) else $error("raw read wrong");
  AST_MASKED: assert property (rd && reg_addr == 12'h118 |=>
    reg_rdata == {2'h0, $past(raw & ena)}) else $error("masked wrong");
  AST_IRQ: assert property (
    irq == $past(|(raw & ena))) else $error("irq level wrong");
  AST_QUIET: assert property (!rd || reg_addr == 12'h11C |=>
    reg_rdata == 32'h0) else $error("read data not zero");

  // Main scenarios reached
  cover property ($rose(irq));
  cover property (|update_ctrl.op_forced_refresh);
  cover property (update_ctrl.global_forced_refresh);
endmodule // pwm_regs_checker

// ===== testbench/pwm_update_and_irq_regs_bench.sv
/*
  Self-checking bench for the PWM update and interrupt register block.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); \
  end \
end
module pwm_update_and_irq_regs_bench;
  logic mclk, rst_n, clk_en, reg_write, reg_read, irq;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, capture_timer, capture_state_in;
  pwm_regs_pkg::pwm_events_s events;
  pwm_regs_pkg::update_ctrl_s update_ctrl;
  int n_mismatch, checks, seed;
  logic [29:0] e_raw, e_ena, v;
  logic [31:0] e_c1, e_c2;
  logic [7:0] cfg, nc;

  pwm_update_and_irq_regs dut (.mclk, .rst_n, .clk_en, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .capture_timer,
    .capture_state_in, .events, .update_ctrl, .irq);

  // Expected update strobes after a config write
  function automatic logic [6:0] exp_upd(input logic [7:0] o,
                                         input logic [7:0] n);
    logic [7:0] t;
    t = o ^ n;
    return {t[7], t[5], t[3], {n[6], n[4], n[2]} & {3{n[0]}}, t[1]};
  endfunction

  // Register write and read cycles
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  // One-cycle event pulse with a fresh capture value
  task automatic pulse(input logic [29:0] p);
    @(posedge mclk);
    events <= p;
    capture_timer <= $random(seed);
    @(posedge mclk);
    events <= '0;
    e_raw = e_raw | p;
    if (p[28]) e_c1 = capture_timer;
    if (p[29]) e_c2 = capture_timer;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #200us;
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    seed = 79998;
    {rst_n, clk_en, reg_write, reg_read} = 4'b0100;
    {reg_addr, reg_wdata, capture_timer, events} = '0;
    capture_state_in = 32'h5A5A_C3C3;
    {n_mismatch, checks, e_raw, e_ena, e_c1, e_c2, cfg} = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(12'h100 + 12'(4 * i), i == 2 ? capture_state_in : 32'h0);
    $display("reset values done");
    for (int i = 0; i < 50; i++) begin
      e_ena = 30'($random(seed));
      wr(12'h110, {2'h0, e_ena});
      rd(12'h110, {2'h0, e_ena});
      pulse(i < 30 ? 30'h1 << i : 30'($random(seed)));
      rd(12'h114, {2'h0, e_raw});
      rd(12'h118, {2'h0, e_raw & e_ena});
      `CHK(irq, |(e_raw & e_ena))
      v = 30'($random(seed));
      wr(12'h11C, {2'h0, v});
      e_raw = e_raw & ~v;
      rd(12'h114, {2'h0, e_raw});
    end
    wr(12'h114, 32'hFFFF_FFFF);
    rd(12'h114, {2'h0, e_raw});
    rd(12'h120, 32'h0);
    // Clock enable low: events and captures must leave no trace
    @(posedge mclk);
    clk_en <= 1'b0;
    events <= 30'h3FFF_FFFF;
    capture_timer <= ~e_c1;
    @(posedge mclk);
    events <= '0;
    clk_en <= 1'b1;
    rd(12'h114, {2'h0, e_raw});
    rd(12'h100, e_c1);
    rd(12'h104, e_c2);
    $display("interrupt sources done");
    for (int i = 0; i < 12; i++) begin
      nc = i < 2 ? {8{i[0]}} : 8'($random(seed));
      wr(12'h10C, {24'h0, nc});
      repeat (2) @(posedge mclk);
      #1;
      `CHK(update_ctrl, exp_upd(cfg, nc))
      cfg = nc;
    end
    $display("update controls done");
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    `CHK(irq, 1'b0)
    `CHK(update_ctrl, 7'h00)
    rd(12'h110, 32'h0);
    rd(12'h114, 32'h0);
    rd(12'h10C, 32'h0);
    $display("second reset done");
    report_and_stop();
  end
endmodule // pwm_update_and_irq_regs_bench

bind pwm_update_and_irq_regs pwm_regs_checker chk (.mclk, .rst_n, .clk_en,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .capture_timer,
  .capture_state_in, .events, .update_ctrl, .irq);
